// [link_shift_in.sv]
// Serial clock domain shifter that builds single and quad line bytes
`timescale 1ns/1ns
`default_nettype none
module link_shift_in
    import otp_lock_pkg::*;
(
    // Link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    input wire logic reset_n,
    // Bytes toward the core domain
    output logic [7:0] single_byte,
    output logic single_toggle,
    output logic single_mid,
    output logic [7:0] quad_byte,
    output logic quad_toggle,
    output logic quad_mid
);
    logic frame_open;
    logic [2:0] edge_count;
    logic [7:0] single_shift;
    logic [7:0] quad_shift;

    // Serial clock stops between frames, so the frame signal ends it
    wire frame_clear = cs_n | ~reset_n;
    wire [2:0] base_count = frame_open ? edge_count : 3'h0;
    wire [2:0] next_edge_count = base_count + 3'h1;
    wire [7:0] next_single_shift = {single_shift[6:0], io_in[0]};
    wire [7:0] next_quad_shift = {quad_shift[3:0], io_in};

    always_ff @(posedge sck or posedge frame_clear)
    begin
        if (frame_clear)
            frame_open <= 1'b0;
        else
            frame_open <= 1'b1;
    end

    // Both widths are built; the core picks one, so no mode crosses here
    always_ff @(posedge sck or negedge reset_n)
    begin
        if (!reset_n)
        begin
            edge_count <= 3'h0;
            single_shift <= 8'h00;
            quad_shift <= 8'h00;
            single_byte <= 8'h00;
            quad_byte <= 8'h00;
            single_toggle <= 1'b0;
            quad_toggle <= 1'b0;
            single_mid <= 1'b0;
            quad_mid <= 1'b0;
        end
        else
        begin
            edge_count <= next_edge_count;
            single_shift <= next_single_shift;
            quad_shift <= next_quad_shift;
            single_mid <= (next_edge_count != 3'h0);
            quad_mid <= next_edge_count[0];
            if (next_edge_count == 3'h0)
            begin
                single_byte <= next_single_shift;
                single_toggle <= ~single_toggle;
            end
            if (!next_edge_count[0])
            begin
                quad_byte <= next_quad_shift;
                quad_toggle <= ~quad_toggle;
            end
        end
    end
endmodule : link_shift_in
`default_nettype wire

// [otp_lock_pkg.sv]
// Constants and types shared by the secured OTP lock control files
// Notes on behaviour
// - Opcode 2Fh writes the security register
// - Security write needs no prior write enable
// - Security write can set customer lock bit
// - Customer lock refuses OTP program, erase, changes
// - Frame not ending on byte boundary is rejected
// - Status bit 0 reports factory lock
// - OTP mode redirects programming into the area
// - OTP mode blocks all main array writes
// - Any lock is permanent, never undone
// - Addresses 000000 to 00000F hold serial number
// - Addresses 000010 to 0001FF are general purpose
// - Opcode B1h enters OTP mode, any width
// - Opcode C1h leaves OTP mode
package otp_lock_pkg;

    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_SECURITY = 8'h2F;
    localparam logic [7:0] OP_ENTER_OTP = 8'hB1;
    localparam logic [7:0] OP_EXIT_OTP = 8'hC1;

    // ------------------------------------------------------------
    // Security register layout
    // ------------------------------------------------------------
    localparam int SEC_FACTORY_BIT = 0;
    localparam int SEC_CUSTOMER_BIT = 1;
    localparam logic [7:0] SEC_RESET = 8'h00;

    // ------------------------------------------------------------
    // OTP area map
    // ------------------------------------------------------------
    localparam logic [23:0] ESN_FIRST = 24'h00_0000;
    localparam logic [23:0] ESN_LAST = 24'h00_000F;
    localparam logic [23:0] GENERAL_FIRST = 24'h00_0010;
    localparam logic [23:0] GENERAL_LAST = 24'h00_01FF;
    localparam logic [1:0] REGION_NONE = 2'h0;
    localparam logic [1:0] REGION_ESN = 2'h1;
    localparam logic [1:0] REGION_GENERAL = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_HZ = 50_000_000;
    localparam int POWERUP_WRITE_DELAY_MS = 10;
    localparam int POWERUP_WRITE_CYCLES =
        CLOCK_HZ / 1000 * POWERUP_WRITE_DELAY_MS;
    localparam int POWERUP_COUNT_W = 20;
    localparam logic [1:0] FRAME_SETTLE_CYCLES = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FRAME,
        ST_SETTLE,
        ST_EXEC
    } frame_state_t;

endpackage : otp_lock_pkg

// [pin_sync.sv]
// Three stage synchroniser that accepts a bit once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Core clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Asynchronous inputs and their accepted values
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] value
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
        end
        else
        begin
            stage1 <= raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_accept
            // Disagreement means a change still settling
            always_ff @(posedge clock or negedge reset_n)
            begin
                if (!reset_n)
                    value[i] <= RESET_VALUE[i];
                else if (stage2[i] == stage3[i])
                    value[i] <= stage3[i];
            end
        end
    endgenerate
endmodule : pin_sync
`default_nettype wire

// [secured_otp_lock_control.sv]
// Secured OTP lock control: instruction decode, lock bits, write gating
`timescale 1ns/1ns
`default_nettype none
module secured_otp_lock_control
    import otp_lock_pkg::*;
#(
    parameter int POWERUP_WAIT = POWERUP_WRITE_CYCLES
) (
    // Core clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    input wire logic quad_instruction_mode,
    // Nonvolatile lock cells, read after reset
    input wire logic factory_lock_strap,
    input wire logic customer_lock_strap,
    // Array write requests from the program and erase logic
    input wire logic array_write_req,
    input wire logic [23:0] array_write_addr,
    // Write decisions
    output logic main_write_grant,
    output logic otp_write_grant,
    output logic write_refused,
    output logic [1:0] write_region,
    output logic [23:0] write_addr,
    // Lock and mode state
    output logic otp_select,
    output logic customer_lock_bit,
    output logic [7:0] security_status,
    output logic lock_program_pulse,
    output logic instr_rejected,
    output logic writes_open
);
    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic [1:0] otp_region_of(input logic [23:0] a);
        logic [1:0] r;
        r = REGION_NONE;
        if (a >= ESN_FIRST && a <= ESN_LAST)
            r = REGION_ESN;
        else if (a >= GENERAL_FIRST && a <= GENERAL_LAST)
            r = REGION_GENERAL;
        return r;
    endfunction : otp_region_of

    localparam logic [POWERUP_COUNT_W-1:0] POWERUP_LAST =
        POWERUP_COUNT_W'(POWERUP_WAIT - 1);

    // ------------------------------------------------------------
    // Link front end and crossing
    // ------------------------------------------------------------
    logic [7:0] single_byte;
    logic [7:0] quad_byte;
    logic single_toggle;
    logic quad_toggle;
    logic single_mid;
    logic quad_mid;
    logic [4:0] synced;

    link_shift_in u_link (
        .sck(sck),
        .cs_n(cs_n),
        .io_in(io_in),
        .reset_n(reset_n),
        .single_byte(single_byte),
        .single_toggle(single_toggle),
        .single_mid(single_mid),
        .quad_byte(quad_byte),
        .quad_toggle(quad_toggle),
        .quad_mid(quad_mid)
    );

    pin_sync #(
        .WIDTH(5),
        .RESET_VALUE(5'h01)
    ) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .raw({quad_mid, single_mid, quad_toggle, single_toggle, cs_n}),
        .value(synced)
    );

    wire cs_level = synced[0];
    wire single_toggle_s = synced[1];
    wire quad_toggle_s = synced[2];
    wire single_mid_s = synced[3];
    wire quad_mid_s = synced[4];

    // ------------------------------------------------------------
    // Core state
    // ------------------------------------------------------------
    frame_state_t state;
    frame_state_t next_state;
    logic frame_quad;
    logic single_seen;
    logic quad_seen;
    logic [1:0] byte_count;
    logic [1:0] settle_count;
    logic [7:0] opcode;
    logic [7:0] data_byte;
    logic straps_loaded;
    logic factory_lock;
    logic [POWERUP_COUNT_W-1:0] powerup_count;
    logic powerup_done;

    // Byte data is stable for a whole byte time after its toggle flips
    wire single_event = single_toggle_s != single_seen;
    wire quad_event = quad_toggle_s != quad_seen;
    wire byte_event = frame_quad ? quad_event : single_event;
    wire [7:0] link_byte = frame_quad ? quad_byte : single_byte;
    wire frame_mid = frame_quad ? quad_mid_s : single_mid_s;
    wire collecting = (state == ST_FRAME) || (state == ST_SETTLE);
    wire take_byte = collecting && byte_event;
    wire [1:0] next_byte_count =
        (byte_count == 2'h3) ? byte_count : byte_count + 2'h1;

    // ------------------------------------------------------------
    // Instruction decode at frame end
    // ------------------------------------------------------------
    wire exec = (state == ST_EXEC);
    wire frame_whole = exec && !frame_mid;
    wire one_byte = frame_whole && (byte_count == 2'h1);
    wire two_bytes = frame_whole && (byte_count == 2'h2);
    wire known_op = (opcode == OP_WRITE_SECURITY) ||
        (opcode == OP_ENTER_OTP) || (opcode == OP_EXIT_OTP);
    wire any_lock = factory_lock || customer_lock_bit;
    wire cmd_enter = one_byte && (opcode == OP_ENTER_OTP);
    wire cmd_exit = one_byte && (opcode == OP_EXIT_OTP);
    // No write enable latch is consulted here
    wire cmd_wsr = two_bytes && (opcode == OP_WRITE_SECURITY) &&
        !otp_select && powerup_done;
    wire set_customer = cmd_wsr && data_byte[SEC_CUSTOMER_BIT] &&
        !any_lock;
    wire cmd_done = cmd_enter || cmd_exit || cmd_wsr;

    wire next_otp_select = cmd_enter ? 1'b1 :
        (cmd_exit ? 1'b0 : otp_select);
    // Lock only ever goes from zero to one once loaded
    wire next_customer_lock = !straps_loaded ? customer_lock_strap :
        (customer_lock_bit || set_customer);
    wire next_factory_lock = !straps_loaded ? factory_lock_strap :
        factory_lock;

    // ------------------------------------------------------------
    // Array write gating
    // ------------------------------------------------------------
    wire [1:0] req_region = otp_region_of(array_write_addr);
    wire otp_ok = array_write_req && otp_select && powerup_done &&
        !any_lock && (req_region != REGION_NONE);
    wire main_ok = array_write_req && !otp_select &&
        powerup_done;

    // ------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
                if (!cs_level)
                    next_state = ST_FRAME;
            ST_FRAME:
                if (cs_level)
                    next_state = ST_SETTLE;
            ST_SETTLE:
                // Late byte toggles may trail the select edge by a cycle
                if (settle_count == FRAME_SETTLE_CYCLES - 2'h1)
                    next_state = ST_EXEC;
            ST_EXEC:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ST_IDLE;
            settle_count <= 2'h0;
            frame_quad <= 1'b0;
        end
        else
        begin
            state <= next_state;
            settle_count <= (state == ST_SETTLE) ?
                settle_count + 2'h1 : 2'h0;
            if (state == ST_IDLE)
                frame_quad <= quad_instruction_mode;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            single_seen <= 1'b0;
            quad_seen <= 1'b0;
            byte_count <= 2'h0;
            opcode <= 8'h00;
            data_byte <= 8'h00;
        end
        else
        begin
            single_seen <= single_toggle_s;
            quad_seen <= quad_toggle_s;
            if (state == ST_IDLE)
                byte_count <= 2'h0;
            else if (take_byte)
                byte_count <= next_byte_count;
            if (take_byte && byte_count == 2'h0)
                opcode <= link_byte;
            if (take_byte && byte_count == 2'h1)
                data_byte <= link_byte;
        end
    end

    // ------------------------------------------------------------
    // Lock bits, mode and powerup guard
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            straps_loaded <= 1'b0;
            factory_lock <= 1'b0;
            customer_lock_bit <= 1'b0;
            security_status <= SEC_RESET;
            otp_select <= 1'b0;
            lock_program_pulse <= 1'b0;
            instr_rejected <= 1'b0;
        end
        else
        begin
            straps_loaded <= 1'b1;
            factory_lock <= next_factory_lock;
            customer_lock_bit <= next_customer_lock;
            security_status <= SEC_RESET;
            security_status[SEC_FACTORY_BIT] <= next_factory_lock;
            security_status[SEC_CUSTOMER_BIT] <= next_customer_lock;
            otp_select <= next_otp_select;
            lock_program_pulse <= set_customer && !customer_lock_bit;
            instr_rejected <= exec && known_op && !cmd_done;
        end
    end

    // Refusing early writes keeps a hasty host harmless
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            powerup_count <= '0;
            powerup_done <= 1'b0;
            writes_open <= 1'b0;
        end
        else
        begin
            if (!powerup_done)
                powerup_count <= powerup_count + 1'b1;
            if (powerup_count == POWERUP_LAST)
                powerup_done <= 1'b1;
            writes_open <= powerup_done;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            main_write_grant <= 1'b0;
            otp_write_grant <= 1'b0;
            write_refused <= 1'b0;
            write_region <= REGION_NONE;
            write_addr <= 24'h00_0000;
        end
        else
        begin
            main_write_grant <= main_ok;
            otp_write_grant <= otp_ok;
            write_refused <= array_write_req && !otp_ok && !main_ok;
            if (array_write_req)
            begin
                write_region <= req_region;
                write_addr <= array_write_addr;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_cs_rise;
        (state == ST_FRAME) && $rose(cs_level);
    endsequence

    sequence s_settle_then_exec;
        (state == ST_SETTLE) [*2] ##1 (state == ST_EXEC);
    endsequence

    property p_frame_end;
        @(posedge clock) disable iff (!reset_n)
        s_cs_rise |=> s_settle_then_exec;
    endproperty
    a_frame_end: assert property (p_frame_end)
        else $error("frame end not evaluated after settle");

    property p_partial_reject;
        @(posedge clock) disable iff (!reset_n)
        (exec && frame_mid && known_op) |=> $stable(customer_lock_bit) &&
            $stable(otp_select) && instr_rejected;
    endproperty
    a_partial_reject: assert property (p_partial_reject)
        else $error("partial byte frame was not rejected");

    property p_set_lock;
        @(posedge clock) disable iff (!reset_n)
        (two_bytes && opcode == OP_WRITE_SECURITY && !otp_select &&
            powerup_done && data_byte[SEC_CUSTOMER_BIT] && !factory_lock)
            |=> customer_lock_bit ##1 customer_lock_bit;
    endproperty
    a_set_lock: assert property (p_set_lock)
        else $error("security write did not set customer lock");

    property p_ignore_bits;
        @(posedge clock) disable iff (!reset_n)
        (cmd_wsr && !data_byte[SEC_CUSTOMER_BIT]) |=>
            $stable(customer_lock_bit) && !lock_program_pulse;
    endproperty
    a_ignore_bits: assert property (p_ignore_bits)
        else $error("lock changed without its data bit");

    property p_lock_sticky;
        @(posedge clock) disable iff (!reset_n)
        (straps_loaded && customer_lock_bit) |=> customer_lock_bit;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("customer lock was cleared");

    property p_status_report;
        @(posedge clock) disable iff (!reset_n)
        straps_loaded |-> (!$past(straps_loaded) || $stable(factory_lock)) &&
            security_status[SEC_FACTORY_BIT] == factory_lock &&
            security_status[SEC_CUSTOMER_BIT] == customer_lock_bit;
    endproperty
    a_status_report: assert property (p_status_report)
        else $error("security status does not match lock bits");

    property p_enter;
        @(posedge clock) disable iff (!reset_n)
        cmd_enter |=> otp_select;
    endproperty
    a_enter: assert property (p_enter)
        else $error("enter command did not select the OTP area");

    property p_exit;
        @(posedge clock) disable iff (!reset_n)
        cmd_exit |=> !otp_select;
    endproperty
    a_exit: assert property (p_exit)
        else $error("exit command did not leave the OTP area");

    property p_main_block;
        @(posedge clock) disable iff (!reset_n)
        (array_write_req && otp_select) |=> !main_write_grant;
    endproperty
    a_main_block: assert property (p_main_block)
        else $error("main array write granted in OTP mode");

    property p_locked_refuse;
        @(posedge clock) disable iff (!reset_n)
        (array_write_req && otp_select && any_lock) |=>
            !otp_write_grant && write_refused;
    endproperty
    a_locked_refuse: assert property (p_locked_refuse)
        else $error("locked OTP area accepted a write");

    property p_esn_region;
        @(posedge clock) disable iff (!reset_n)
        (array_write_req && otp_select && !any_lock && powerup_done &&
            array_write_addr <= ESN_LAST) |=>
            otp_write_grant && write_region == REGION_ESN;
    endproperty
    a_esn_region: assert property (p_esn_region)
        else $error("serial number write not granted as such");

    property p_general_region;
        @(posedge clock) disable iff (!reset_n)
        (array_write_req && otp_select && !any_lock && powerup_done &&
            array_write_addr >= GENERAL_FIRST &&
            array_write_addr <= GENERAL_LAST) |=>
            otp_write_grant && write_region == REGION_GENERAL;
    endproperty
    a_general_region: assert property (p_general_region)
        else $error("general region write not granted as such");

    property p_early_write;
        @(posedge clock) disable iff (!reset_n)
        (array_write_req && !powerup_done) |=>
            write_refused && !main_write_grant;
    endproperty
    a_early_write: assert property (p_early_write)
        else $error("write granted before powerup delay");

endmodule : secured_otp_lock_control
`default_nettype wire

// [secured_otp_lock_control_tb.sv]
// Self-checking bench for the secured OTP lock control
`timescale 1ns/1ns
`default_nettype none
module secured_otp_lock_control_tb;
    import otp_lock_pkg::*;
    logic clock = 1'b0, reset_n = 1'b0, quad = 1'b0, factory = 1'b0;
    logic req = 1'b0, go = 1'b0, cstrap = 1'b0, seen_rej, seen_lpp;
    logic [23:0] addr = 24'h00_0000;
    logic [15:0] frame = 16'h0000;
    logic [4:0] nbits = 5'h10;
    logic sck, cs_n, done, main_g, otp_g, refused, otp_sel, lock, lpp, rej;
    logic open;
    logic [3:0] io;
    logic [1:0] region;
    logic [7:0] status;
    logic [23:0] waddr;
    int miscompares = 0;
    int comparisons = 0;
    always #10 clock = ~clock;
    spi_host_model HOST (.go(go), .quad(quad), .frame(frame), .nbits(nbits),
        .sck(sck), .cs_n(cs_n), .io(io), .done(done));
    secured_otp_lock_control #(.POWERUP_WAIT(16)) DUT (.clock(clock),
        .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .io_in(io),
        .quad_instruction_mode(quad), .factory_lock_strap(factory),
        .customer_lock_strap(cstrap), .array_write_req(req),
        .array_write_addr(addr), .main_write_grant(main_g),
        .otp_write_grant(otp_g), .write_refused(refused),
        .write_region(region), .write_addr(waddr), .otp_select(otp_sel),
        .customer_lock_bit(lock), .security_status(status),
        .lock_program_pulse(lpp), .instr_rejected(rej), .writes_open(open));
    task automatic summarize;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [23:0] exp,
        input logic [23:0] got);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Fixed watch window also keeps chip select high between frames
    task automatic send(input logic [15:0] f, input logic [4:0] n,
        input logic q);
        int k;
        @(posedge clock);
        quad <= q;
        frame <= f;
        nbits <= n;
        go <= 1'b1;
        for (k = 0; k < 200 && done !== 1'b1; k++) @(posedge clock);
        if (done !== 1'b1)
        begin
            miscompares++;
            summarize();
        end
        go <= 1'b0;
        seen_rej = 1'b0;
        seen_lpp = 1'b0;
        repeat (20)
        begin
            @(posedge clock);
            #1 seen_rej |= rej;
            seen_lpp |= lpp;
        end
    endtask : send
    // Expected: 4 main grant, 2 OTP grant, 1 refused
    task automatic wreq(input logic [23:0] a, input logic [2:0] exp);
        @(posedge clock);
        req <= 1'b1;
        addr <= a;
        @(posedge clock);
        req <= 1'b0;
        #1 chk("grants", {21'h0, exp}, {21'h0, main_g, otp_g, refused});
    endtask : wreq
    task automatic do_reset(input logic fl);
        int k;
        @(posedge clock);
        reset_n <= 1'b0;
        factory <= fl;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1 chk("status", {16'h0, 6'h0, cstrap, fl}, {16'h0, status});
        wreq(24'h10_0000, 3'h1);
        for (k = 0; k < 40 && open !== 1'b1; k++) @(posedge clock) #1;
        chk("writes_open", 24'h1, {23'h0, open});
        $display("test reset done");
    endtask : do_reset
    task automatic t_otp_mode;
        send({OP_ENTER_OTP, 8'h00}, 5'h08, 1'b1);
        chk("otp_select", 24'h1, {23'h0, otp_sel});
        wreq(24'h10_0000, 3'h1);
        wreq(24'h00_0005, 3'h2);
        chk("region", 24'h1, {22'h0, region});
        chk("write_addr", 24'h00_0005, waddr);
        wreq(24'h00_01FF, 3'h2);
        chk("region", 24'h2, {22'h0, region});
        wreq(24'h00_0200, 3'h1);
        send({OP_WRITE_SECURITY, 8'h02}, 5'h10, 1'b0);
        chk("rejected", 24'h1, {23'h0, seen_rej});
        send({OP_EXIT_OTP, 8'h00}, 5'h08, 1'b0);
        chk("otp_select", 24'h0, {23'h0, otp_sel});
        wreq(24'h10_0000, 3'h4);
        $display("test otp mode done");
    endtask : t_otp_mode
    task automatic t_lock;
        send({OP_WRITE_SECURITY, 8'h02}, 5'h0D, 1'b0);
        chk("partial", 24'h2, {22'h0, seen_rej, lock});
        send({OP_WRITE_SECURITY, 8'hFD}, 5'h10, 1'b0);
        chk("other bits", 24'h0, {22'h0, seen_rej, lock});
        send({OP_WRITE_SECURITY, 8'h02}, 5'h10, 1'b1);
        chk("lock", 24'h3, {22'h0, lock, seen_lpp});
        chk("status", 24'h02, {16'h0, status});
        cstrap <= 1'b1;
        send({OP_ENTER_OTP, 8'h00}, 5'h08, 1'b0);
        chk("otp_select", 24'h1, {23'h0, otp_sel});
        wreq(24'h00_0010, 3'h1);
        send({OP_EXIT_OTP, 8'h00}, 5'h08, 1'b1);
        send({OP_WRITE_SECURITY, 8'h00}, 5'h10, 1'b0);
        chk("lock kept", 24'h1, {23'h0, lock});
        $display("test customer lock done");
    endtask : t_lock
    task automatic t_factory;
        do_reset(1'b1);
        send({OP_ENTER_OTP, 8'h00}, 5'h08, 1'b0);
        wreq(24'h00_0005, 3'h1);
        send({OP_EXIT_OTP, 8'h00}, 5'h08, 1'b0);
        $display("test factory lock done");
    endtask : t_factory
    initial
    begin
        do_reset(1'b0);
        t_otp_mode();
        t_lock();
        t_factory();
        summarize();
    end
endmodule : secured_otp_lock_control_tb
`default_nettype wire

// [spi_host_model.sv]
// Host controller model that frames instructions on the serial link
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    // Request from the bench
    input wire logic go,
    input wire logic quad,
    input wire logic [15:0] frame,
    input wire logic [4:0] nbits,
    // Serial link
    output logic sck,
    output logic cs_n,
    output logic [3:0] io,
    output logic done
);
    int i;
    initial
    begin
        {sck, cs_n, io, done} = 7'h20;
    end
    // Clock stands still outside frames; lines released show inverse
    always @(posedge go)
    begin
        #7 cs_n = 1'b0;
        for (i = 0; i < nbits; i += (quad ? 4 : 1))
        begin
            io = quad ? frame[15-i -: 4] : {~io[3:1], frame[15-i]};
            #24 sck = 1'b1;
            #24 sck = 1'b0;
        end
        #24 cs_n = 1'b1;
        io = ~io;
        done = 1'b1;
        wait (!go);
        done = 1'b0;
    end
endmodule : spi_host_model
`default_nettype wire
